// file: common/touch_key_defines.vh
`ifndef TOUCH_KEY_DEFINES_VH
`define TOUCH_KEY_DEFINES_VH

// Register byte offsets on the APB bus
`define TK_OFS_CTRL      8'h00
`define TK_OFS_OSCFREQ   8'h04
`define TK_OFS_CALIB_HI  8'h08
`define TK_OFS_CALIB_LO  8'h0C
`define TK_OFS_SENSE_HI  8'h10
`define TK_OFS_SENSE_LO  8'h14
`define TK_OFS_REFCAP_HI 8'h18
`define TK_OFS_REFCAP_LO 8'h1C
`define TK_OFS_SELHOP    8'h20
`define TK_OFS_OSCKEY    8'h24
`define TK_OFS_PRELOAD   8'h28

// touch_control_status fields
`define TK_BIT_SLOT_OVF  6
`define TK_BIT_START     5
`define TK_BIT_SENSE_OVF 4
`define TK_BIT_CALIB_OVF 3

// oscillator_key_enables fields
`define TK_BIT_TSS       7
`define TK_BIT_REF_EN    5
`define TK_BIT_KEY_EN    4

// Reset values
`define TK_RST_OSCFREQ   2'h3
`define TK_RST_BYTE      8'h00

// Timing counts
`define TK_UNIT_LAST     5'h1F
`define TK_SLOT_LAST     8'hFF
`define TK_COUNT_LAST    16'hFFFF
`define TK_DIV4_LAST     2'h3

`endif

// file: hw/touch_key_measurement_unit.v
// Functional notes
// - Slot overflow sets slot flag and irq request, stops all oscillators.
// - Slot overflow switches off sense, calibration, unit and slot counters.
// - Software writing slot flag leaves irq request alone; clear by writing zero.
// - Start bit low clears sense, calibration, unit counters; slot counter kept.
// - Start bit rising starts all counters and oscillators together.
// - Sense counter overflow sets sticky flag until software writes zero.
// - Calibration counter overflow sets sticky flag until software writes zero.
// - Calibration clock select: sys, sys/2, sys/4, sys/8.
// - Two-bit oscillator frequency select, reset value 11.
// - Calibration count frozen at slot overflow, readable high and low byte.
// - Sense count frozen at slot overflow, readable high and low byte.
// - Ten-bit reference capacitor code drives reference oscillator capacitor.
// - Mux field routes key 1..4 to the sense counter.
// - Frequency double bit doubles key oscillator frequency.
// - Filter enable bit turns filter function on or off.
// - Hop control bit: hardware hops, else software hop field.
// - Three-bit software hop field selects hopping frequency.
// - Slot clock select: reference oscillator or sys/4.
// - Reference oscillator enable bit lets it run.
// - Key oscillator enable bit lets sense oscillator run.
// - Bits 0..3 enable keys 1..4.
// - Unimplemented control bits ignore writes, read zero.
// - Window lasts (256 - preload) * 32 slot clock periods.
`timescale 1ns/10ps
`include "touch_key_defines.vh"

module touch_key_measurement_unit
(
	input  wire        i_clock,         // System clock, 20 MHz
	input  wire        i_rstn,          // Synchronous reset, active low
	input  wire        i_psel,          // APB select
	input  wire        i_penable,       // APB enable
	input  wire        i_pwrite,        // APB direction
	input  wire [7:0]  i_paddr,         // APB byte address
	input  wire [31:0] i_pwdata,        // APB write data
	output wire [31:0] o_prdata,        // APB read data
	output wire        o_pready,        // APB ready
	output wire        o_pslverr,       // APB error, unmapped address
	input  wire [3:0]  i_key_osc,       // Key sense oscillator outputs
	input  wire        i_ref_osc,       // Reference oscillator output
	input  wire        i_irq_ack,       // Interrupt controller clears request
	output wire        o_touch_irq,     // Touch interrupt request flag
	output wire        o_ref_osc_run,   // Reference oscillator run
	output wire        o_key_osc_run,   // Key oscillators run
	output wire [1:0]  o_osc_freq_sel,  // Oscillator nominal frequency
	output wire [9:0]  o_ref_cap_code,  // Reference capacitor code
	output wire        o_freq_double,   // Key oscillator doubling
	output wire        o_filter_en,     // Filter function enable
	output wire [2:0]  o_hop_sel,       // Effective hop frequency select
	output wire [3:0]  o_key_enable,    // Per key enables
	output wire [1:0]  o_key_mux_sel    // Key routed to sense counter
);

	// Register state
	reg        slot_overflow_flag_q;
	reg        measure_start_q;
	reg        sense_count_overflow_flag_q;
	reg        calib_count_overflow_flag_q;
	reg [1:0]  calib_clock_select_q;
	reg [1:0]  osc_frequency_select_q;
	reg [9:0]  ref_capacitor_code_q;
	reg [7:0]  sense_select_hopping_q;
	reg [7:0]  oscillator_key_enables_q;
	reg [7:0]  slot_preload_q;
	reg        touch_irq_request_q;

	// Measurement state
	reg        start_prev_q;
	reg        running_q;
	reg [2:0]  presc_q;
	reg [4:0]  unit_q;
	reg [7:0]  slot_q;
	reg [15:0] calib_q;
	reg [15:0] sense_q;
	reg [2:0]  hop_hw_q;

	// Output flops
	reg [31:0] prdata_q;
	reg        pready_q;
	reg        pslverr_q;
	reg        ref_run_q;
	reg        key_run_q;
	reg [2:0]  hop_sel_q;

	wire [4:0] osc_in;
	wire [4:0] osc_edge;

	assign osc_in = {i_ref_osc, i_key_osc};

	// Three-stage synchronisers; an edge counts once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < 5; g = g + 1)
		begin : g_sync
			reg [2:0] sync_q;
			reg       level_q;
			// Accepted level moves only when stages two and three agree
			always @(posedge i_clock)
			begin
				if (!i_rstn)
				begin
					sync_q  <= 3'h0;
					level_q <= 1'b0;
				end
				else
				begin
					sync_q <= {sync_q[1:0], osc_in[g]};
					if (sync_q[1] == sync_q[2])
						level_q <= sync_q[2];
				end
			end
			// Rising edge once both late stages show high; a lone stage-two blip is ignored
			assign osc_edge[g] = sync_q[1] & sync_q[2] & ~level_q;
		end
	endgenerate

	// Address decode, shared by write enable and error answer
	function addr_hit;
		input [7:0] a;
		begin
			addr_hit = (a <= `TK_OFS_PRELOAD) && (a[1:0] == 2'h0);
		end
	endfunction

	// Calibration tick from the prescaler that runs only with the window
	function calib_tick;
		input [1:0] sel;
		input [2:0] p;
		begin
			case (sel)
				2'h0:    calib_tick = 1'b1;
				2'h1:    calib_tick = p[0];
				2'h2:    calib_tick = &p[1:0];
				default: calib_tick = &p;
			endcase
		end
	endfunction

	wire       bus_take;
	wire       wr_en;
	wire       ctrl_wr;
	wire       start_rise;
	wire       slot_clk_tick;
	wire       unit_wrap;
	wire       slot_ovf_evt;
	wire       cal_tick;
	wire       key_gate;
	wire       sense_tick;
	wire       sense_ovf_evt;
	wire       calib_ovf_evt;
	reg        running_d;
	reg [31:0] rd_word;

	// Access completes at the edge where pready is already high
	assign bus_take = i_psel & i_penable & pready_q;
	assign wr_en    = bus_take & i_pwrite & addr_hit(i_paddr);
	// Control word write, shared by the three flag paths
	assign ctrl_wr  = wr_en & (i_paddr == `TK_OFS_CTRL);

	assign start_rise = measure_start_q & ~start_prev_q;

	// Slot clock source: reference oscillator or sys/4
	assign slot_clk_tick = oscillator_key_enables_q[`TK_BIT_TSS] ?
		(presc_q[1:0] == `TK_DIV4_LAST) :
		(oscillator_key_enables_q[`TK_BIT_REF_EN] & osc_edge[4]);

	assign unit_wrap    = running_q & slot_clk_tick & (unit_q == `TK_UNIT_LAST);
	assign slot_ovf_evt = unit_wrap & (slot_q == `TK_SLOT_LAST);

	assign cal_tick = running_q & calib_tick(calib_clock_select_q, presc_q);

	// Only an enabled key on a running key oscillator produces edges
	assign key_gate = oscillator_key_enables_q[`TK_BIT_KEY_EN] &
		oscillator_key_enables_q[sense_select_hopping_q[7:6]];
	assign sense_tick = running_q & key_gate & osc_edge[sense_select_hopping_q[7:6]];

	assign sense_ovf_evt = sense_tick & (sense_q == `TK_COUNT_LAST);
	assign calib_ovf_evt = cal_tick & (calib_q == `TK_COUNT_LAST);

	// Window state: opens on start rise, closes on slot overflow
	always @*
	begin
		running_d = running_q;
		if (!measure_start_q)
			running_d = 1'b0;
		else if (start_rise)
			running_d = 1'b1;
		else if (slot_ovf_evt)
			running_d = 1'b0;
	end

	// Read mux; narrow registers sit low, the rest reads zero
	always @*
	begin
		rd_word = 32'h0;
		case (i_paddr)
			`TK_OFS_CTRL:      rd_word[7:0] = {1'b0, slot_overflow_flag_q, measure_start_q,
				sense_count_overflow_flag_q, calib_count_overflow_flag_q, 1'b0,
				calib_clock_select_q};
			`TK_OFS_OSCFREQ:   rd_word[1:0] = osc_frequency_select_q;
			`TK_OFS_CALIB_HI:  rd_word[7:0] = calib_q[15:8];
			`TK_OFS_CALIB_LO:  rd_word[7:0] = calib_q[7:0];
			`TK_OFS_SENSE_HI:  rd_word[7:0] = sense_q[15:8];
			`TK_OFS_SENSE_LO:  rd_word[7:0] = sense_q[7:0];
			`TK_OFS_REFCAP_HI: rd_word[1:0] = ref_capacitor_code_q[9:8];
			`TK_OFS_REFCAP_LO: rd_word[7:0] = ref_capacitor_code_q[7:0];
			`TK_OFS_SELHOP:    rd_word[7:0] = sense_select_hopping_q;
			`TK_OFS_OSCKEY:    rd_word[7:0] = oscillator_key_enables_q;
			`TK_OFS_PRELOAD:   rd_word[7:0] = slot_preload_q;
			default:           rd_word = 32'h0;
		endcase
	end

	// APB slave: one wait state, then ready with data or error
	always @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0;
		end
		else
		begin
			pready_q  <= i_psel & i_penable & ~pready_q;
			pslverr_q <= i_psel & i_penable & ~pready_q & ~addr_hit(i_paddr);
			prdata_q  <= (i_psel & i_penable & ~pready_q & ~i_pwrite) ? rd_word : 32'h0;
		end
	end

	// Plain software registers; unused bits are never stored
	always @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			measure_start_q          <= 1'b0;
			calib_clock_select_q     <= 2'h0;
			osc_frequency_select_q   <= `TK_RST_OSCFREQ;
			ref_capacitor_code_q     <= 10'h000;
			sense_select_hopping_q   <= `TK_RST_BYTE;
			oscillator_key_enables_q <= `TK_RST_BYTE;
			slot_preload_q           <= `TK_RST_BYTE;
		end
		else if (wr_en)
		begin
			case (i_paddr)
				`TK_OFS_CTRL:
				begin
					measure_start_q      <= i_pwdata[`TK_BIT_START];
					calib_clock_select_q <= i_pwdata[1:0];
				end
				`TK_OFS_OSCFREQ:   osc_frequency_select_q <= i_pwdata[1:0];
				`TK_OFS_REFCAP_HI: ref_capacitor_code_q[9:8] <= i_pwdata[1:0];
				`TK_OFS_REFCAP_LO: ref_capacitor_code_q[7:0] <= i_pwdata[7:0];
				`TK_OFS_SELHOP:    sense_select_hopping_q <= i_pwdata[7:0];
				`TK_OFS_OSCKEY:    oscillator_key_enables_q <= i_pwdata[7:0] & 8'hBF;
				`TK_OFS_PRELOAD:   slot_preload_q <= i_pwdata[7:0];
				default:           slot_preload_q <= slot_preload_q;
			endcase
		end
	end

	// Sticky flags: hardware set wins over a same-cycle software write
	always @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			slot_overflow_flag_q        <= 1'b0;
			sense_count_overflow_flag_q <= 1'b0;
			calib_count_overflow_flag_q <= 1'b0;
			touch_irq_request_q         <= 1'b0;
		end
		else
		begin
			// A software write to the slot flag never touches the request
			if (slot_ovf_evt)
				slot_overflow_flag_q <= 1'b1;
			else if (ctrl_wr)
				slot_overflow_flag_q <= i_pwdata[`TK_BIT_SLOT_OVF];
			if (sense_ovf_evt)
				sense_count_overflow_flag_q <= 1'b1;
			else if (ctrl_wr)
				sense_count_overflow_flag_q <= i_pwdata[`TK_BIT_SENSE_OVF];
			if (calib_ovf_evt)
				calib_count_overflow_flag_q <= 1'b1;
			else if (ctrl_wr)
				calib_count_overflow_flag_q <= i_pwdata[`TK_BIT_CALIB_OVF];
			if (slot_ovf_evt)
				touch_irq_request_q <= 1'b1;
			else if (i_irq_ack)
				touch_irq_request_q <= 1'b0;
		end
	end

	// Measurement counters
	always @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			start_prev_q <= 1'b0;
			running_q    <= 1'b0;
			presc_q      <= 3'h0;
			unit_q       <= 5'h00;
			slot_q       <= 8'h00;
			calib_q      <= 16'h0000;
			sense_q      <= 16'h0000;
			hop_hw_q     <= 3'h0;
		end
		else
		begin
			start_prev_q <= measure_start_q;
			running_q    <= running_d;
			// Prescaler idles at zero so each window starts in phase
			presc_q      <= running_q ? presc_q + 3'h1 : 3'h0;
			if (!measure_start_q)
			begin
				unit_q  <= 5'h00;
				calib_q <= 16'h0000;
				sense_q <= 16'h0000;
			end
			else
			begin
				if (running_q && slot_clk_tick)
					unit_q <= unit_q + 5'h01;
				if (cal_tick)
					calib_q <= calib_q + 16'h0001;
				if (sense_tick)
					sense_q <= sense_q + 16'h0001;
			end
			// Slot counter keeps its value while idle; loads preload on start
			if (start_rise)
				slot_q <= slot_preload_q;
			else if (unit_wrap)
				slot_q <= slot_q + 8'h01;
			if (start_rise)
				hop_hw_q <= hop_hw_q + 3'h1;
		end
	end

	// Oscillator controls follow the window, stopped at overflow
	always @(posedge i_clock)
	begin
		if (!i_rstn)
		begin
			ref_run_q <= 1'b0;
			key_run_q <= 1'b0;
			hop_sel_q <= 3'h0;
		end
		else
		begin
			ref_run_q <= running_d & oscillator_key_enables_q[`TK_BIT_REF_EN];
			key_run_q <= running_d & oscillator_key_enables_q[`TK_BIT_KEY_EN];
			hop_sel_q <= sense_select_hopping_q[3] ? hop_hw_q :
				sense_select_hopping_q[2:0];
		end
	end

	assign o_prdata       = prdata_q;
	assign o_pready       = pready_q;
	assign o_pslverr      = pslverr_q;
	assign o_touch_irq    = touch_irq_request_q;
	assign o_ref_osc_run  = ref_run_q;
	assign o_key_osc_run  = key_run_q;
	assign o_osc_freq_sel = osc_frequency_select_q;
	assign o_ref_cap_code = ref_capacitor_code_q;
	assign o_freq_double  = sense_select_hopping_q[5];
	assign o_filter_en    = sense_select_hopping_q[4];
	assign o_hop_sel      = hop_sel_q;
	assign o_key_enable   = oscillator_key_enables_q[3:0];
	assign o_key_mux_sel  = sense_select_hopping_q[7:6];

endmodule // touch_key_measurement_unit

// file: testbench/tb_top.sv
`timescale 1ns/10ps
`include "touch_key_defines.vh"
module tb_top;
	logic        i_clock = 1'b0, i_rstn = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
	logic        i_pwrite = 1'b0, i_irq_ack = 1'b0, i_ref_osc, o_pready, o_pslverr, rd_err;
	logic        o_touch_irq, o_ref_osc_run, o_key_osc_run, o_freq_double, o_filter_en;
	logic [1:0]  o_osc_freq_sel, o_key_mux_sel;
	logic [2:0]  o_hop_sel;
	logic [3:0]  i_key_osc, o_key_enable;
	logic [7:0]  i_paddr = 8'h00;
	logic [9:0]  o_ref_cap_code;
	logic [15:0] sense, calib, rd16;
	logic [31:0] i_pwdata = 32'h0, o_prdata, rdat;
	int          num_errors = 0, total_checks = 0;

	touch_key_measurement_unit u_touch_key_measurement_unit (.i_clock, .i_rstn, .i_psel,
		.i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
		.i_key_osc, .i_ref_osc, .i_irq_ack, .o_touch_irq, .o_ref_osc_run, .o_key_osc_run,
		.o_osc_freq_sel, .o_ref_cap_code, .o_freq_double, .o_filter_en, .o_hop_sel,
		.o_key_enable, .o_key_mux_sel);
	touch_pad_model u_touch_pad_model (.i_clock, .i_key_run(o_key_osc_run),
		.i_ref_run(o_ref_osc_run), .o_key_osc(i_key_osc), .o_ref_osc(i_ref_osc));

	// 20 MHz system clock
	initial forever #25 i_clock = ~i_clock;

	task print_verdict;
		if (num_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task give_up(input int n, input int lim);
		if (n >= lim)
		begin
			num_errors++;
			print_verdict;
		end
	endtask
	// Request held until ready is sampled; idle edge after release
	task apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		i_psel <= 1'b1;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= {24'h0, d};
		@(posedge i_clock);
		i_penable <= 1'b1;
		for (n = 0; o_pready !== 1'b1 && n < 20; n++) @(posedge i_clock);
		give_up(n, 20);
		rdat = o_prdata;
		rd_err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_clock);
	endtask
	task rdc(input logic [7:0] a, input logic [7:0] e, input string name);
		apb(1'b0, a, 8'h00);
		chk(name, rdat, {24'h0, e});
	endtask
	task wrc(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e, input string name);
		apb(1'b1, a, d);
		rdc(a, e, name);
	endtask
	task read16(input logic [7:0] ah, output logic [15:0] v);
		apb(1'b0, ah, 8'h00);
		v[15:8] = rdat[7:0];
		apb(1'b0, ah + 8'h04, 8'h00);
		v[7:0] = rdat[7:0];
	endtask
	task rng(input string name, input logic [15:0] v, input logic [16:0] exp, input logic [16:0] tol);
		chk(name, {31'h0, (v + tol >= exp) && (v <= exp + tol)}, 32'h1);
	endtask
	// Start a window, wait for its end, acknowledge, fetch both counts
	task meas(input logic [1:0] sel, input logic [7:0] pre);
		int n;
		apb(1'b1, `TK_OFS_PRELOAD, pre);
		apb(1'b1, `TK_OFS_CTRL, {6'h00, sel});
		apb(1'b1, `TK_OFS_CTRL, {6'h08, sel});
		for (n = 0; o_touch_irq !== 1'b1 && n < 90000; n++) @(posedge i_clock);
		give_up(n, 90000);
		i_irq_ack <= 1'b1;
		@(posedge i_clock);
		i_irq_ack <= 1'b0;
		@(posedge i_clock);
		read16(`TK_OFS_CALIB_HI, calib);
		read16(`TK_OFS_SENSE_HI, sense);
	endtask

	// Main sequence: reset values, fields, four short windows, one long window, one short window with the key off
	initial
	begin
		repeat (12) @(posedge i_clock);
		i_rstn <= 1'b1;
		@(posedge i_clock);
		rdc(`TK_OFS_OSCFREQ, 8'h03, "osc_freq");
		rdc(`TK_OFS_CTRL, 8'h00, "control");
		chk("freq_sel", o_osc_freq_sel, 2'h3);
		wrc(`TK_OFS_OSCFREQ, 8'hFC, 8'h00, "osc_freq");
		wrc(`TK_OFS_REFCAP_HI, 8'hFF, 8'h03, "cap_high");
		wrc(`TK_OFS_REFCAP_LO, 8'hA5, 8'hA5, "cap_low");
		wrc(`TK_OFS_SELHOP, 8'h72, 8'h72, "select_hop");
		wrc(`TK_OFS_OSCKEY, 8'hFF, 8'hBF, "osc_key");
		wrc(`TK_OFS_CTRL, 8'h84, 8'h00, "control");
		wrc(`TK_OFS_CALIB_HI, 8'hFF, 8'h00, "calib_high");
		apb(1'b0, 8'h2C, 8'h00);
		chk("unmapped", rd_err, 1'b1);
		repeat (2) @(posedge i_clock);
		chk("freq_sel", o_osc_freq_sel, 2'h0);
		chk("cap_code", o_ref_cap_code, 10'h3A5);
		chk("mux", o_key_mux_sel, 2'h1);
		chk("double", o_freq_double, 1'b1);
		chk("filter", o_filter_en, 1'b1);
		chk("hop", o_hop_sel, 3'h2);
		chk("keys", o_key_enable, 4'hF);
		for (int k = 0; k < 4; k++)
		begin
			apb(1'b1, `TK_OFS_SELHOP, {k[1:0], 6'h00});
			meas(k[1:0], 8'hFF);
			rng("sense", sense, 17'h10 >> k, 17'h2);
			rng("calib", calib, 17'h80 >> k, 17'h2);
			rdc(`TK_OFS_CTRL, {6'h18, k[1:0]}, "control");
			chk("key_run", o_key_osc_run, 1'b0);
			chk("ref_run", o_ref_osc_run, 1'b0);
			read16(`TK_OFS_SENSE_HI, rd16);
			chk("sense_frozen", rd16, sense);
			apb(1'b1, `TK_OFS_CTRL, 8'h40);
			chk("irq", o_touch_irq, 1'b0);
			read16(`TK_OFS_SENSE_HI, rd16);
			chk("sense_clear", rd16, 16'h0);
			read16(`TK_OFS_CALIB_HI, rd16);
			chk("calib_clear", rd16, 16'h0);
			wrc(`TK_OFS_CTRL, 8'h00, 8'h00, "control");
		end
		apb(1'b1, `TK_OFS_SELHOP, 8'h08);
		repeat (2) @(posedge i_clock);
		chk("hop", o_hop_sel, 3'h4);
		apb(1'b1, `TK_OFS_OSCKEY, 8'h3F);
		meas(2'h0, 8'h00);
		rdc(`TK_OFS_CTRL, 8'h68, "control");
		rng("sense", sense, 17'h2800, 17'h10);
		rng("calib", calib, 17'h4000, 17'h10);
		wrc(`TK_OFS_CTRL, 8'h00, 8'h00, "control");
		// Selected key disabled: window still runs, sense count stays zero, calibration counts
		apb(1'b1, `TK_OFS_OSCKEY, 8'h9E);
		meas(2'h0, 8'hFF);
		chk("sense_off", sense, 16'h0);
		rng("calib_on", calib, 17'h80, 17'h2);
		print_verdict;
	end
endmodule // tb_top

// file: testbench/touch_key_assertions.sv
`timescale 1ns/10ps
module touch_key_checker
(
	input wire        i_clock,        // Clock
	input wire        i_rstn,         // Reset, active low
	input wire        i_psel,         // Select
	input wire        i_penable,      // Enable
	input wire        i_pwrite,       // Direction
	input wire [7:0]  i_paddr,        // Address
	input wire [31:0] o_prdata,       // Read data
	input wire        o_pready,       // Ready
	input wire        o_pslverr,      // Error
	input wire        i_irq_ack,      // Request clear
	input wire        o_touch_irq,    // Request flag
	input wire        o_ref_osc_run,  // Reference run
	input wire        o_key_osc_run,  // Key run
	input wire [3:0]  o_key_enable,   // Key enables
	input wire [1:0]  o_key_mux_sel   // Key route
);
	// Decoded bus events
	wire bad_addr = (i_paddr > 8'h28) || (i_paddr[1:0] != 2'h0);
	wire wr_done  = i_psel && i_penable && i_pwrite && o_pready;

	// One clock domain, so one default clock and reset
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn);

	property p_stop_end;
		$rose(o_touch_irq) |-> ##[0:2] (!o_key_osc_run && !o_ref_osc_run);
	endproperty
	a_stop_end: assert property (p_stop_end) else $error("Oscillators run after end");
	property p_irq_hold;
		o_touch_irq && !i_irq_ack |=> o_touch_irq;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("Request dropped");
	property p_run_min;
		$rose(o_key_osc_run) |=> o_key_osc_run [*8];
	endproperty
	a_run_min: assert property (p_run_min) else $error("Window too short");
	property p_cfg_hold;
		!wr_done && !$past(wr_done) |=> $stable(o_key_mux_sel) && $stable(o_key_enable);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("Field moved without write");
	property p_err_map;
		o_pready |-> (o_pslverr == bad_addr);
	endproperty
	a_err_map: assert property (p_err_map) else $error("Wrong error response");
	property p_rd_idle;
		!(o_pready && !i_pwrite) |-> (o_prdata == 32'h0);
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("Read data outside read");
	property p_rdy_late;
		i_psel && i_penable && !o_pready |=> o_pready;
	endproperty
	a_rdy_late: assert property (p_rdy_late) else $error("Ready late");
	property p_rdy_pulse;
		o_pready |=> !o_pready;
	endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("Ready longer than one cycle");

	c_irq: cover property ($rose(o_touch_irq));
	c_err: cover property (o_pslverr);
	c_run: cover property ($rose(o_key_osc_run));
endmodule // touch_key_checker

bind touch_key_measurement_unit touch_key_checker u_touch_key_checker (.i_clock, .i_rstn,
	.i_psel, .i_penable, .i_pwrite, .i_paddr, .o_prdata, .o_pready, .o_pslverr, .i_irq_ack,
	.o_touch_irq, .o_ref_osc_run, .o_key_osc_run, .o_key_enable, .o_key_mux_sel);

// file: testbench/touch_pad_model.sv
`timescale 1ns/10ps
module touch_pad_model
(
	input  wire       i_clock,    // System clock
	input  wire       i_key_run,  // Key oscillators run
	input  wire       i_ref_run,  // Reference oscillator run
	output wire [3:0] o_key_osc,  // Pad outputs, key1 in bit 0
	output wire       o_ref_osc   // Reference output
);
	logic [5:0] phase_q   = 6'h00;
	logic [2:0] ref_cnt_q = 3'h0;
	logic       ref_q     = 1'b0;

	// Key n period is 8 << n cycles, reference 10; all slow enough to sync
	always @(posedge i_clock)
	begin
		phase_q <= phase_q + 6'h01;
		ref_cnt_q <= (ref_cnt_q == 3'h4) ? 3'h0 : ref_cnt_q + 3'h1;
		ref_q <= (ref_cnt_q == 3'h4) ? ~ref_q : ref_q;
	end

	// Stopped oscillators stand still low
	assign o_key_osc = (i_key_run === 1'b1) ? phase_q[5:2] : 4'h0;
	assign o_ref_osc = (i_ref_run === 1'b1) ? ref_q : 1'b0;
endmodule // touch_pad_model
